/* File: design/bt_params.svh */
// constants for the bus timeout timer block
`ifndef BT_PARAMS_SVH
`define BT_PARAMS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define BT_OFS_HOLD_DATA 5'h10
`define BT_OFS_STRETCH_DATA 5'h12
`define BT_OFS_SYSCON_DATA 5'h14
`define BT_OFS_CONTROL 5'h16

// ----------------------------------------
// control field layout
// ----------------------------------------
`define BT_SEL_HI 7
`define BT_SEL_LO 6
`define BT_MODE_HI 5
`define BT_MODE_LO 0
`define BT_MODE_PATTERN 6'h34

// ----------------------------------------
// reset values
// ----------------------------------------
`define BT_COUNT_RESET 16'h0000

// ----------------------------------------
// timing
// ----------------------------------------
`define BT_CLK_PERIOD_NS 40
`define BT_FAST_PERIOD_NS 100
`define BT_SLOW_PERIOD_NS 800
`define BT_SLOW_DIV (`BT_SLOW_PERIOD_NS / `BT_FAST_PERIOD_NS)

`endif

/* File: design/bt_pkg.sv */
// types for the bus timeout timer block
package bt_pkg;

  // byte write from the host i/o port
  typedef struct packed {
    logic sel;
    logic wr;
    logic [4:0] addr;
    logic [7:0] data;
  } bt_wr_t;

  // bus activity levels
  typedef struct packed {
    logic syscon;
    logic exp_cyc;
    logic host_pend;
    logic xfer_busy;
    logic hold_active;
  } bt_bus_t;

  // timer select codes
  typedef enum logic [1:0] {
    BT_SEL_HOLD = 2'h0,
    BT_SEL_STRETCH = 2'h1,
    BT_SEL_SYSCON = 2'h2,
    BT_SEL_RSVD = 2'h3
  } bt_sel_t;

  // byte loader states
  typedef enum logic [2:0] {
    BT_LD_IDLE = 3'h1,
    BT_LD_LSB = 3'h2,
    BT_LD_MSB = 3'h4
  } bt_ld_state_t;

endpackage

/* File: design/bt_down_counter.sv */
// reloadable down counter with expiry flag
`timescale 1ns/100ps
`default_nettype none
module bt_down_counter #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // control
  input wire logic tick_in,
  input wire logic start_in,
  input wire logic run_in,
  input wire logic armed_in,
  input wire logic [WIDTH-1:0] load_in,
  // status
  output logic expired_out
);

  logic [WIDTH-1:0] cnt_reg;

  // ----------------------------------------
  // count and expiry
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt_reg <= '0;
      expired_out <= 1'b0;
    end else if (start_in) begin
      cnt_reg <= load_in;
      expired_out <= 1'b0;
    end else if (!run_in || !armed_in) begin
      expired_out <= 1'b0;
    end else if (tick_in && !expired_out) begin
      if (cnt_reg <= WIDTH'(1)) begin
        expired_out <= 1'b1;
      end else begin
        cnt_reg <= cnt_reg - WIDTH'(1);
      end
    end
  end

endmodule // bt_down_counter
`default_nettype wire

/* File: design/bt_timers.sv */
// three bus timeout timers with byte-wide load port
`timescale 1ns/100ps
`default_nettype none
`include "bt_params.svh"
module bt_timers #(
  parameter int COUNT_W = 16
) (
  // clock and reset
  input wire logic CLK_IN,
  input wire logic RST_IN,
  // host i/o write port
  input wire bt_pkg::bt_wr_t BUS_WR_IN,
  // bus activity pins
  input wire bt_pkg::bt_bus_t BUS_PINS_IN,
  // bus control
  output logic RELEASE_BUS_OUT,
  output logic HOST_RETRY_OUT,
  output logic EXP_BERR_OUT,
  // status
  output logic [2:0] TIMER_ARMED_OUT
);
  import bt_pkg::*;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  bt_bus_t s1_reg;
  bt_bus_t s2_reg;
  bt_bus_t s3_reg;
  bt_bus_t bus_reg;
  bt_bus_t bus_prev_reg;

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= BUS_PINS_IN;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // level accepted once stages two and three agree
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      bus_reg <= '0;
    end else begin
      for (int i = 0; i < $bits(bt_bus_t); i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          bus_reg[i] <= s3_reg[i];
        end
      end
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      bus_prev_reg <= '0;
    end else begin
      bus_prev_reg <= bus_reg;
    end
  end

  // ----------------------------------------
  // time bases
  // ----------------------------------------
  localparam logic [7:0] ACC_STEP = 8'(`BT_CLK_PERIOD_NS);
  localparam logic [7:0] ACC_WRAP = 8'(`BT_FAST_PERIOD_NS);
  localparam logic [3:0] SLOW_LAST = 4'(`BT_SLOW_DIV - 1);

  logic [7:0] acc_reg;
  logic fast_tick_reg;
  logic [3:0] slow_cnt_reg;
  logic slow_tick_reg;

  // fractional divider, averages one tick per 100 ns
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      acc_reg <= '0;
      fast_tick_reg <= 1'b0;
    end else if (acc_reg + ACC_STEP >= ACC_WRAP) begin
      acc_reg <= acc_reg + ACC_STEP - ACC_WRAP;
      fast_tick_reg <= 1'b1;
    end else begin
      acc_reg <= acc_reg + ACC_STEP;
      fast_tick_reg <= 1'b0;
    end
  end

  // slow tick, every eighth fast tick
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      slow_cnt_reg <= '0;
      slow_tick_reg <= 1'b0;
    end else if (fast_tick_reg) begin
      slow_cnt_reg <= (slow_cnt_reg == SLOW_LAST) ? 4'h0 : slow_cnt_reg + 4'h1;
      slow_tick_reg <= (slow_cnt_reg == SLOW_LAST);
    end else begin
      slow_tick_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // write decode
  // ----------------------------------------
  function automatic logic hit(input bt_wr_t w, input logic [4:0] ofs);
    hit = w.sel && w.wr && (w.addr == ofs);
  endfunction

  logic ctrl_wr;
  logic [2:0] data_wr;
  bt_sel_t ctrl_sel;

  assign ctrl_wr = hit(BUS_WR_IN, `BT_OFS_CONTROL);
  assign data_wr[0] = hit(BUS_WR_IN, `BT_OFS_HOLD_DATA);
  assign data_wr[1] = hit(BUS_WR_IN, `BT_OFS_STRETCH_DATA);
  assign data_wr[2] = hit(BUS_WR_IN, `BT_OFS_SYSCON_DATA);
  assign ctrl_sel = bt_sel_t'(BUS_WR_IN.data[`BT_SEL_HI:`BT_SEL_LO]);

  // ----------------------------------------
  // byte loader
  // ----------------------------------------
  bt_ld_state_t ld_state_reg;
  logic [1:0] ld_sel_reg;
  logic [7:0] lsb_reg;
  logic [COUNT_W-1:0] load_reg [3];
  logic [2:0] armed_reg;
  logic sel_wr;

  assign sel_wr = data_wr[ld_sel_reg];

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      ld_state_reg <= BT_LD_IDLE;
      ld_sel_reg <= 2'h0;
    end else if (ctrl_wr) begin
      if (ctrl_sel != BT_SEL_RSVD) begin
        ld_sel_reg <= ctrl_sel;
      end
      ld_state_reg <= (ctrl_sel == BT_SEL_RSVD) ? BT_LD_IDLE : BT_LD_LSB;
    end else begin
      case (ld_state_reg)
        BT_LD_LSB: begin
          if (sel_wr) begin
            ld_state_reg <= BT_LD_MSB;
          end
        end
        BT_LD_MSB: begin
          if (sel_wr) begin
            ld_state_reg <= BT_LD_IDLE;
          end
        end
        default: begin
          ld_state_reg <= BT_LD_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      lsb_reg <= 8'h00;
    end else if (ld_state_reg == BT_LD_LSB && sel_wr && !ctrl_wr) begin
      lsb_reg <= BUS_WR_IN.data;
    end
  end

  // control write disarms the chosen timer until both bytes land
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      armed_reg <= 3'h0;
      for (int i = 0; i < 3; i++) begin
        load_reg[i] <= `BT_COUNT_RESET;
      end
    end else if (ctrl_wr) begin
      if (ctrl_sel != BT_SEL_RSVD) begin
        armed_reg[ctrl_sel] <= 1'b0;
      end
    end else if (ld_state_reg == BT_LD_MSB && sel_wr) begin
      load_reg[ld_sel_reg] <= {BUS_WR_IN.data, lsb_reg};
      armed_reg[ld_sel_reg] <= 1'b1;
    end
  end

  // ----------------------------------------
  // timers
  // ----------------------------------------
  logic hold_exp;
  logic stretch_exp;
  logic syscon_exp;

  bt_down_counter #(.WIDTH(COUNT_W)) hold_timer (
    .clk_in(CLK_IN),
    .rst_in(RST_IN),
    .tick_in(fast_tick_reg),
    .start_in(bus_reg.hold_active && !bus_prev_reg.hold_active),
    .run_in(bus_reg.hold_active),
    .armed_in(armed_reg[0]),
    .load_in(load_reg[0]),
    .expired_out(hold_exp)
  );

  bt_down_counter #(.WIDTH(COUNT_W)) stretch_timer (
    .clk_in(CLK_IN),
    .rst_in(RST_IN),
    .tick_in(fast_tick_reg),
    .start_in(bus_reg.host_pend && !bus_prev_reg.host_pend),
    .run_in(bus_reg.host_pend),
    .armed_in(armed_reg[1]),
    .load_in(load_reg[1]),
    .expired_out(stretch_exp)
  );

  bt_down_counter #(.WIDTH(COUNT_W)) syscon_timer (
    .clk_in(CLK_IN),
    .rst_in(RST_IN),
    .tick_in(slow_tick_reg),
    .start_in(bus_reg.exp_cyc && !bus_prev_reg.exp_cyc),
    .run_in(bus_reg.exp_cyc && bus_reg.syscon),
    .armed_in(armed_reg[2]),
    .load_in(load_reg[2]),
    .expired_out(syscon_exp)
  );

  // ----------------------------------------
  // bus actions
  // ----------------------------------------
  logic release_next;
  logic retry_next;
  logic berr_next;

  // release waits for the transfer in flight, holds until tenure ends
  assign release_next = bus_reg.hold_active &&
    (RELEASE_BUS_OUT || (hold_exp && !bus_reg.xfer_busy));
  // abort only the host side; expansion transfer is left running
  assign retry_next = bus_reg.host_pend && stretch_exp;
  assign berr_next = bus_reg.exp_cyc && bus_reg.syscon && syscon_exp;

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      RELEASE_BUS_OUT <= 1'b0;
    end else begin
      RELEASE_BUS_OUT <= release_next;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      HOST_RETRY_OUT <= 1'b0;
    end else begin
      HOST_RETRY_OUT <= retry_next;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      EXP_BERR_OUT <= 1'b0;
    end else begin
      EXP_BERR_OUT <= berr_next;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      TIMER_ARMED_OUT <= 3'h0;
    end else begin
      TIMER_ARMED_OUT <= armed_reg;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (RST_IN);

  release_after_xfer_a: assert property (
    (bus_reg.hold_active && hold_exp && !bus_reg.xfer_busy) |=> RELEASE_BUS_OUT)
    else $error("bus not released after hold expiry");

  release_needs_tenure_a: assert property (
    RELEASE_BUS_OUT |-> $past(bus_reg.hold_active))
    else $error("release outside tenure");

  count_byte_order_a: assert property (
    (ld_state_reg == BT_LD_MSB && sel_wr && !ctrl_wr) |=>
      (load_reg[$past(ld_sel_reg)] == {$past(BUS_WR_IN.data), lsb_reg}))
    else $error("count bytes paired wrongly");

  stretch_retry_a: assert property (
    (bus_reg.host_pend && stretch_exp) |=> HOST_RETRY_OUT)
    else $error("no retry after stretch expiry");

  stretch_keeps_exp_a: assert property (
    (HOST_RETRY_OUT && !bus_reg.syscon) |-> !EXP_BERR_OUT)
    else $error("expansion cycle disturbed by stretch abort");

  syscon_berr_a: assert property (
    (bus_reg.exp_cyc && bus_reg.syscon && syscon_exp) |=> EXP_BERR_OUT)
    else $error("no bus error on syscon expiry");

  syscon_only_a: assert property (
    !bus_reg.syscon |=> !EXP_BERR_OUT)
    else $error("bus error while not system controller");

  reserved_select_a: assert property (
    (ctrl_wr && ctrl_sel == BT_SEL_RSVD) |=> (ld_state_reg == BT_LD_IDLE && $stable(armed_reg)))
    else $error("reserved select armed a timer");

  fast_tick_rate_a: assert property (
    fast_tick_reg |-> ##[2:3] fast_tick_reg)
    else $error("fast tick spacing wrong");

  slow_on_fast_a: assert property (
    slow_tick_reg |-> $past(fast_tick_reg) && $past(slow_cnt_reg) == SLOW_LAST)
    else $error("slow tick not on eighth fast tick");

  restart_clears_a: assert property (
    (bus_reg.hold_active && !bus_prev_reg.hold_active) |=> !hold_exp)
    else $error("hold timer not restarted");

endmodule // bt_timers
`default_nettype wire

/* File: tb/bt_host_model.sv */
// host and expansion bus model facing the timeout timers
`timescale 1ns/100ps
`default_nettype none
module bt_host_model (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // requested bus activity
  input wire bt_pkg::bt_bus_t want_in,
  // timer responses
  input wire logic release_in,
  input wire logic retry_in,
  input wire logic berr_in,
  // bus activity pins
  output bt_pkg::bt_bus_t pins_out
);
  import bt_pkg::*;
  logic gave_reg;
  logic retried_reg;
  logic aborted_reg;
  // ----------------------------------------
  // reactions to the timers
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    gave_reg <= (rst_in || !want_in.hold_active) ? 1'b0 : (gave_reg || release_in);
    retried_reg <= (rst_in || !want_in.host_pend) ? 1'b0 : (retried_reg || retry_in);
    aborted_reg <= (rst_in || !want_in.exp_cyc) ? 1'b0 : (aborted_reg || berr_in);
  end
  always_comb begin
    pins_out = want_in;
    pins_out.hold_active = want_in.hold_active && !gave_reg;
    pins_out.host_pend = want_in.host_pend && !retried_reg;
    pins_out.exp_cyc = want_in.exp_cyc && !aborted_reg;
  end
endmodule // bt_host_model
`default_nettype wire

/* File: tb/test_bus_timeout_timers.sv */
// self-checking bench for the bus timeout timers
`timescale 1ns/100ps
`default_nettype none
`include "bt_params.svh"
module test_bus_timeout_timers;
  import bt_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  bt_wr_t wr_s = '0;
  bt_bus_t want = '0;
  bt_bus_t pins;
  logic rel;
  logic retry;
  logic berr;
  logic [2:0] armed;
  logic [2:0] outv;
  int n_mismatch = 0;
  int num_checks = 0;
  int n;
  logic [4:0] ofs [3] = '{`BT_OFS_HOLD_DATA, `BT_OFS_STRETCH_DATA, `BT_OFS_SYSCON_DATA};
  logic [15:0] cnt [3] = '{16'h0102, 16'h0004, 16'h0003};
  assign outv = {berr, retry, rel};
  always #20 clk = ~clk;
  bt_timers DUT (.CLK_IN(clk), .RST_IN(rst), .BUS_WR_IN(wr_s), .BUS_PINS_IN(pins), .RELEASE_BUS_OUT(rel),
    .HOST_RETRY_OUT(retry), .EXP_BERR_OUT(berr), .TIMER_ARMED_OUT(armed));
  bt_host_model host (.clk_in(clk), .rst_in(rst), .want_in(want), .release_in(rel), .retry_in(retry),
    .berr_in(berr), .pins_out(pins));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic summarize();
    if (n_mismatch == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_s <= '{sel: 1'b1, wr: 1'b1, addr: a, data: d};
    @(posedge clk);
    wr_s <= '0;
  endtask
  task automatic ld(input logic [1:0] s, input logic [4:0] a, input logic [15:0] c);
    wr(`BT_OFS_CONTROL, {s, `BT_MODE_PATTERN});
    wr(a, c[7:0]);
    wr(a, c[15:8]);
  endtask
  task automatic meas(input int w, output int k);
    k = 0;
    while (outv[w] !== 1'b1 && k < 3000) begin
      @(posedge clk);
      #1;
      k++;
    end
  endtask
  // delay in cycles against count times tick, tick in tenths of a cycle
  task automatic rng(input string nm, input int k, input int c, input int t10);
    chk(nm, 32'(k * 10 >= 30 + (c - 1) * t10 && k * 10 <= 80 + (c + 1) * t10), 32'h1);
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    tick(1);
    chk("outs_reset", 32'({armed, outv}), 32'h0);
    for (int s = 0; s < 3; s++) begin
      ld(2'(s), ofs[s], cnt[s]);
      tick(3);
      chk("armed_bit", 32'(armed[s]), 32'h1);
    end
    wr(`BT_OFS_CONTROL, 8'hF4);
    tick(3);
    chk("armed_rsvd", 32'(armed), 32'h7);
    @(posedge clk);
    want.hold_active <= 1'b1;
    meas(0, n);
    rng("hold_delay", n, 258, 25);
    @(posedge clk);
    want.hold_active <= 1'b0;
    tick(8);
    chk("release_end", 32'(rel), 32'h0);
    @(posedge clk);
    want <= '{syscon: 1'b0, exp_cyc: 1'b0, host_pend: 1'b0, xfer_busy: 1'b1, hold_active: 1'b1};
    tick(700);
    chk("release_busy", 32'(rel), 32'h0);
    @(posedge clk);
    want.xfer_busy <= 1'b0;
    meas(0, n);
    chk("release_after", 32'(n <= 8), 32'h1);
    @(posedge clk);
    want.hold_active <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      want.host_pend <= 1'b1;
      tick(3);
      @(posedge clk);
      want.host_pend <= 1'b0;
      tick(8);
    end
    chk("retry_short", 32'(retry), 32'h0);
    wr(`BT_OFS_CONTROL, 8'h74);
    wr(`BT_OFS_STRETCH_DATA, 8'h05);
    ld(2'h1, `BT_OFS_STRETCH_DATA, 16'h0002);
    tick(3);
    chk("armed_restart", 32'(armed[1]), 32'h1);
    @(posedge clk);
    want.exp_cyc <= 1'b1;
    want.host_pend <= 1'b1;
    meas(1, n);
    rng("retry_delay", n, 2, 25);
    tick(30);
    chk("berr_stretch", 32'(berr), 32'h0);
    @(posedge clk);
    want.host_pend <= 1'b0;
    tick(150);
    chk("berr_noctl", 32'({berr, retry}), 32'h0);
    @(posedge clk);
    want.exp_cyc <= 1'b0;
    want.syscon <= 1'b1;
    tick(8);
    @(posedge clk);
    want.exp_cyc <= 1'b1;
    meas(2, n);
    rng("berr_delay", n, 3, 200);
    @(posedge clk);
    want.exp_cyc <= 1'b0;
    tick(8);
    chk("berr_end", 32'(berr), 32'h0);
    wr(`BT_OFS_CONTROL, 8'h34);
    wr(`BT_OFS_HOLD_DATA, 8'h7B);
    tick(3);
    chk("armed_lone", 32'(armed[0]), 32'h0);
    summarize();
  end
  initial begin
    #(40 * 20000);
    n_mismatch++;
    summarize();
  end
endmodule // test_bus_timeout_timers
`default_nettype wire
